// [hdl/ftm_map.vh]
// How it works
// - Period counted by gating an 11.25 kHz internal tick into an 8-bit counter.
// - Measurement restarts on each PWM rising edge when config_two bit 2 set.
// - Count from second to fourth tach rising edge, or until counter saturates.
// - Measurement repeats while monitoring and config_two bit 2 stay enabled, stops when either is cleared.
// - Each finished count is stored in tach_period_count at index 0x08.
// - fan_profile_one bits 7:6 divide count tick by 1, 2, 4 or 8.
// - Count equals oscillator frequency times 60 over RPM times N.
// - config_one bit 3 inverts PWM pin; set means high at full duty.
// - Fault pin is active-low open-drain, enabled by config_one bit 4, default on.
// - Fault pin asserts only after five consecutive tach failures.
// - Failure only when reading exceeds tach limit; without a PWM rising edge to restart it, a fan that stops after the second tach edge reads 0xFF.
// - Each failure sets irq_status_one bit 1; asserts interrupt only if config_one bit 1 set.
// - Reading irq_status_one releases the interrupt output.
// - After each failure PWM is held at full drive for the spin-up time, 2 s.
// - Measurement and interrupts continue after the fault pin asserts.
// - Fault pin released once the fan recovers; normal drive resumes.
// - part_code and maker_code are read-only fixed identification codes.
// - silicon_rev_therm bits 3:0 give revision, bit 7 is a writable enable.
// - config_one bit 0 enables monitoring; cleared at reset.
// - config_one bit 2 selects digital tach when 0, analog sense when 1.
// - Tach high limit at index 0x10 resets to 0xFF.
`ifndef FTM_MAP_VH
`define FTM_MAP_VH
`define FTM_IDX_CFG1 6'h00
`define FTM_IDX_CFG2 6'h01
`define FTM_IDX_STS1 6'h02
`define FTM_IDX_STS2 6'h03
`define FTM_IDX_TEST 6'h07
`define FTM_IDX_READ 6'h08
`define FTM_IDX_LIMIT 6'h10
`define FTM_IDX_PROF1 6'h20
`define FTM_IDX_DRIVE 6'h22
`define FTM_IDX_FILT 6'h23
`define FTM_IDX_LAUTO 6'h24
`define FTM_IDX_RAUTO 6'h25
`define FTM_IDX_PART 6'h3D
`define FTM_IDX_MAKER 6'h3E
`define FTM_IDX_REV 6'h3F
`define FTM_RST_CFG1 8'h90
`define FTM_RST_CFG2 8'h7F
`define FTM_RST_LIMIT 8'hFF
`define FTM_RST_PROF1 8'h5D
`define FTM_RST_DRIVE 8'h55
`define FTM_RST_FILT 8'h55
`define FTM_RST_LAUTO 8'h41
`define FTM_RST_RAUTO 8'h61
`define FTM_RST_REVEN 1'b0
`define FTM_CFG1_MON 0
`define FTM_CFG1_INTEN 1
`define FTM_CFG1_ANALOG 2
`define FTM_CFG1_INV 3
`define FTM_CFG1_FLTEN 4
`define FTM_CFG2_MEAS 2
`define FTM_STS1_FAN 1
`define FTM_REV_EN 7
`define FTM_PROF_RANGE_HI 7
`define FTM_PROF_RANGE_LO 6
`define FTM_CLK_HZ 10000000
`define FTM_OSC_HZ 11250
`define FTM_OSC_DIV (`FTM_CLK_HZ / `FTM_OSC_HZ)
`define FTM_SPINUP_MS 2000
`define FTM_SPINUP_CYC (`FTM_SPINUP_MS * (`FTM_CLK_HZ / 1000))
`define FTM_FAIL_LIMIT 3'd5
`define FTM_PWM_SLOTS 4'd15
`define FTM_PWM_STEP_CYC 10'd667
`define FTM_COUNT_MAX 8'hFF
`define FTM_TACH_START 3'd2
`define FTM_TACH_STOP 3'd4
`define FTM_RESP_OKAY 2'b00
`define FTM_RESP_SLVERR 2'b10
`endif

// [hdl/ftm_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "ftm_map.vh"
module ftm_top #(
    parameter integer SPINUP_CYCLES = `FTM_SPINUP_CYC,
    parameter [7:0] PART_CODE = 8'hA5,
    parameter [7:0] MAKER_CODE = 8'h5A,
    parameter [3:0] REVISION = 4'h1
) (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_s_axi_awvalid,
    output wire o_s_axi_awready,
    input wire [7:0] i_s_axi_awaddr,
    input wire i_s_axi_wvalid,
    output wire o_s_axi_wready,
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    output wire o_s_axi_bvalid,
    input wire i_s_axi_bready,
    output wire [1:0] o_s_axi_bresp,
    input wire i_s_axi_arvalid,
    output wire o_s_axi_arready,
    input wire [7:0] i_s_axi_araddr,
    output wire o_s_axi_rvalid,
    input wire i_s_axi_rready,
    output wire [31:0] o_s_axi_rdata,
    output wire [1:0] o_s_axi_rresp,
    input wire i_tach_sense_in,
    output wire o_pwm_out,
    output wire o_fan_fault_n_out,
    output wire o_fan_fault_n_oe,
    output wire o_int_n
);
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_ARM = 2'd1;
    localparam [1:0] ST_COUNT = 2'd2;
    localparam integer SPIN_LAST = SPINUP_CYCLES - 1;
    localparam integer OSC_LAST = `FTM_OSC_DIV - 1;
    localparam [9:0] STEP_LAST = `FTM_PWM_STEP_CYC - 10'd1;

    // Register file
    reg [7:0] cfg1_q, cfg2_q, limit_q, prof1_q, drive_q, filt_q, lauto_q, rauto_q;
    reg rev_en_q;
    reg [7:0] read_q;
    reg sts_fan_q;
    reg int_q;

    // AXI4-Lite slave
    reg awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    reg [1:0] bresp_q, rresp_q;
    reg [31:0] rdata_q;
    reg [5:0] aw_idx_q;
    reg [31:0] wdata_q;
    reg wstrb0_q;
    wire aw_hs = i_s_axi_awvalid & awready_q;
    wire w_hs = i_s_axi_wvalid & wready_q;
    wire wr_go = ~awready_q & ~wready_q & ~bvalid_q;
    wire ar_hs = i_s_axi_arvalid & arready_q;
    wire [5:0] ar_idx = i_s_axi_araddr[7:2];
    wire rd_sts1 = ar_hs & (ar_idx == `FTM_IDX_STS1);
    wire wr_en = wr_go & wstrb0_q;
    wire [7:0] wb = wdata_q[7:0];

    reg wr_hit;
    always @* begin
        wr_hit = 1'b1;
        if (aw_idx_q == `FTM_IDX_CFG1) begin
            wr_hit = 1'b1;
        end else if (aw_idx_q == `FTM_IDX_CFG2) begin
            wr_hit = 1'b1;
        end else if (aw_idx_q == `FTM_IDX_LIMIT) begin
            wr_hit = 1'b1;
        end else if (aw_idx_q == `FTM_IDX_PROF1) begin
            wr_hit = 1'b1;
        end else if (aw_idx_q == `FTM_IDX_DRIVE) begin
            wr_hit = 1'b1;
        end else if (aw_idx_q == `FTM_IDX_FILT) begin
            wr_hit = 1'b1;
        end else if (aw_idx_q == `FTM_IDX_LAUTO) begin
            wr_hit = 1'b1;
        end else if (aw_idx_q == `FTM_IDX_RAUTO) begin
            wr_hit = 1'b1;
        end else if (aw_idx_q == `FTM_IDX_REV) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    reg [7:0] rd_val;
    reg rd_hit;
    always @* begin
        rd_val = 8'h00;
        rd_hit = 1'b1;
        if (ar_idx == `FTM_IDX_CFG1) begin
            rd_val = cfg1_q;
        end else if (ar_idx == `FTM_IDX_CFG2) begin
            rd_val = cfg2_q;
        end else if (ar_idx == `FTM_IDX_STS1) begin
            rd_val = {6'h00, sts_fan_q, 1'b0};
        end else if (ar_idx == `FTM_IDX_STS2) begin
            rd_val = 8'h00;
        end else if (ar_idx == `FTM_IDX_TEST) begin
            rd_val = 8'h00;
        end else if (ar_idx == `FTM_IDX_READ) begin
            rd_val = read_q;
        end else if (ar_idx == `FTM_IDX_LIMIT) begin
            rd_val = limit_q;
        end else if (ar_idx == `FTM_IDX_PROF1) begin
            rd_val = prof1_q;
        end else if (ar_idx == `FTM_IDX_DRIVE) begin
            rd_val = drive_q;
        end else if (ar_idx == `FTM_IDX_FILT) begin
            rd_val = filt_q;
        end else if (ar_idx == `FTM_IDX_LAUTO) begin
            rd_val = lauto_q;
        end else if (ar_idx == `FTM_IDX_RAUTO) begin
            rd_val = rauto_q;
        end else if (ar_idx == `FTM_IDX_PART) begin
            rd_val = PART_CODE;
        end else if (ar_idx == `FTM_IDX_MAKER) begin
            rd_val = MAKER_CODE;
        end else if (ar_idx == `FTM_IDX_REV) begin
            rd_val = {rev_en_q, 3'b000, REVISION};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `FTM_RESP_OKAY;
            aw_idx_q <= 6'h00;
            wdata_q <= 32'h00000000;
            wstrb0_q <= 1'b0;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= `FTM_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            if (aw_hs) begin
                awready_q <= 1'b0;
                aw_idx_q <= i_s_axi_awaddr[7:2];
            end
            if (w_hs) begin
                wready_q <= 1'b0;
                wdata_q <= i_s_axi_wdata;
                wstrb0_q <= i_s_axi_wstrb[0];
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `FTM_RESP_OKAY : `FTM_RESP_SLVERR;
            end else if (bvalid_q & i_s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
            if (ar_hs) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= {24'h000000, rd_val};
                rresp_q <= rd_hit ? `FTM_RESP_OKAY : `FTM_RESP_SLVERR;
            end else if (rvalid_q & i_s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg1_q <= `FTM_RST_CFG1;
            cfg2_q <= `FTM_RST_CFG2;
            limit_q <= `FTM_RST_LIMIT;
            prof1_q <= `FTM_RST_PROF1;
            drive_q <= `FTM_RST_DRIVE;
            filt_q <= `FTM_RST_FILT;
            lauto_q <= `FTM_RST_LAUTO;
            rauto_q <= `FTM_RST_RAUTO;
            rev_en_q <= `FTM_RST_REVEN;
        end else if (wr_en) begin
            if (aw_idx_q == `FTM_IDX_CFG1) begin
                cfg1_q <= wb;
            end else if (aw_idx_q == `FTM_IDX_CFG2) begin
                cfg2_q <= wb;
            end else if (aw_idx_q == `FTM_IDX_LIMIT) begin
                limit_q <= wb;
            end else if (aw_idx_q == `FTM_IDX_PROF1) begin
                prof1_q <= wb;
            end else if (aw_idx_q == `FTM_IDX_DRIVE) begin
                drive_q <= wb;
            end else if (aw_idx_q == `FTM_IDX_FILT) begin
                filt_q <= wb;
            end else if (aw_idx_q == `FTM_IDX_LAUTO) begin
                lauto_q <= wb;
            end else if (aw_idx_q == `FTM_IDX_RAUTO) begin
                rauto_q <= wb;
            end else if (aw_idx_q == `FTM_IDX_REV) begin
                rev_en_q <= wb[`FTM_REV_EN];
            end
        end
    end

    // Tach input synchroniser; stage one feeds only stage two
    reg tach_s1_q, tach_s2_q, tach_prev_q;
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tach_s1_q <= 1'b1;
            tach_s2_q <= 1'b1;
            tach_prev_q <= 1'b1;
        end else begin
            tach_s1_q <= i_tach_sense_in;
            tach_s2_q <= tach_s1_q;
            tach_prev_q <= tach_s2_q;
        end
    end
    // Analog sense mode expects the conditioned pulses on the same pin
    wire tach_rise = tach_s2_q & ~tach_prev_q;

    // Count tick: 11.25 kHz base divided by the speed range
    reg [9:0] osc_cnt_q;
    reg [2:0] pre_q;
    wire osc_tick = ({22'h000000, osc_cnt_q} == OSC_LAST);
    wire [1:0] range = prof1_q[`FTM_PROF_RANGE_HI:`FTM_PROF_RANGE_LO];
    reg range_hit;
    always @* begin
        case (range)
            2'b00: range_hit = 1'b1;
            2'b01: range_hit = (pre_q[0] == 1'b0);
            2'b10: range_hit = (pre_q[1:0] == 2'b00);
            default: range_hit = (pre_q == 3'b000);
        endcase
    end
    wire cnt_tick = osc_tick & range_hit;
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            osc_cnt_q <= 10'h000;
            pre_q <= 3'b000;
        end else if (osc_tick) begin
            osc_cnt_q <= 10'h000;
            pre_q <= pre_q + 3'b001;
        end else begin
            osc_cnt_q <= osc_cnt_q + 10'h001;
        end
    end

    // PWM generator: 15 slots, duty nibble gives high slots
    reg [9:0] step_q;
    reg [3:0] slot_q;
    reg [24:0] spin_q;
    reg spin_on_q;
    reg drive_prev_q;
    reg pwm_q;
    wire pwm_raw = (slot_q < drive_q[3:0]);
    wire drive_lvl = spin_on_q | pwm_raw;
    wire pwm_rise = drive_lvl & ~drive_prev_q;
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            step_q <= 10'h000;
            slot_q <= 4'h0;
            drive_prev_q <= 1'b0;
            pwm_q <= 1'b0;
        end else begin
            drive_prev_q <= drive_lvl;
            // Pin is low at full drive unless the inversion bit is set
            pwm_q <= ~(drive_lvl ^ cfg1_q[`FTM_CFG1_INV]);
            if (step_q == STEP_LAST) begin
                step_q <= 10'h000;
                slot_q <= (slot_q == `FTM_PWM_SLOTS - 4'd1) ? 4'h0 : slot_q + 4'h1;
            end else begin
                step_q <= step_q + 10'h001;
            end
        end
    end

    // Measurement sequencer
    reg [1:0] state_q;
    reg [2:0] pulses_q;
    reg [7:0] count_q;
    reg [2:0] fails_q;
    reg fault_oe_q;
    reg done;
    reg [7:0] done_val;
    wire meas_on = cfg1_q[`FTM_CFG1_MON] & cfg2_q[`FTM_CFG2_MEAS];
    wire fail = done & (done_val > limit_q);
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            pulses_q <= 3'd0;
            count_q <= 8'h00;
        end else if (!meas_on) begin
            state_q <= ST_IDLE;
        end else if (pwm_rise) begin
            state_q <= ST_ARM;
            pulses_q <= 3'd0;
            count_q <= 8'h00;
        end else begin
            case (state_q)
                ST_ARM: begin
                    if (tach_rise) begin
                        pulses_q <= pulses_q + 3'd1;
                        if (pulses_q + 3'd1 == `FTM_TACH_START) begin
                            state_q <= ST_COUNT;
                        end
                    end
                end
                ST_COUNT: begin
                    if (tach_rise) begin
                        pulses_q <= pulses_q + 3'd1;
                    end
                    if (cnt_tick && count_q != `FTM_COUNT_MAX) begin
                        count_q <= count_q + 8'h01;
                    end
                    if (done) begin
                        state_q <= ST_ARM;
                        pulses_q <= 3'd0;
                        count_q <= 8'h00;
                    end
                end
                default: begin
                    state_q <= ST_ARM;
                    pulses_q <= 3'd0;
                    count_q <= 8'h00;
                end
            endcase
        end
    end

    always @* begin
        done = 1'b0;
        done_val = count_q;
        if (meas_on && !pwm_rise && state_q == ST_COUNT) begin
            if (tach_rise && pulses_q + 3'd1 == `FTM_TACH_STOP) begin
                done = 1'b1;
            end else if (cnt_tick && count_q == `FTM_COUNT_MAX - 8'h01) begin
                done = 1'b1;
                done_val = `FTM_COUNT_MAX;
            end
        end
    end

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            read_q <= 8'h00;
            sts_fan_q <= 1'b0;
            int_q <= 1'b0;
            fails_q <= 3'd0;
            fault_oe_q <= 1'b0;
            spin_on_q <= 1'b0;
            spin_q <= 25'd0;
        end else begin
            if (done) begin
                read_q <= done_val;
            end
            // A failure in the same cycle as the status read wins
            if (fail) begin
                sts_fan_q <= 1'b1;
                int_q <= cfg1_q[`FTM_CFG1_INTEN];
            end else if (rd_sts1) begin
                sts_fan_q <= 1'b0;
                int_q <= 1'b0;
            end
            if (fail) begin
                if (fails_q != `FTM_FAIL_LIMIT) begin
                    fails_q <= fails_q + 3'd1;
                end
            end else if (done) begin
                fails_q <= 3'd0;
            end
            fault_oe_q <= cfg1_q[`FTM_CFG1_FLTEN] & (fails_q == `FTM_FAIL_LIMIT);
            if (fail) begin
                spin_on_q <= 1'b1;
                spin_q <= 25'd0;
            end else if (spin_on_q) begin
                if ({7'h00, spin_q} == SPIN_LAST) begin
                    spin_on_q <= 1'b0;
                end else begin
                    spin_q <= spin_q + 25'd1;
                end
            end
        end
    end

    assign o_s_axi_awready = awready_q;
    assign o_s_axi_wready = wready_q;
    assign o_s_axi_bvalid = bvalid_q;
    assign o_s_axi_bresp = bresp_q;
    assign o_s_axi_arready = arready_q;
    assign o_s_axi_rvalid = rvalid_q;
    assign o_s_axi_rdata = rdata_q;
    assign o_s_axi_rresp = rresp_q;
    assign o_pwm_out = pwm_q;
    assign o_fan_fault_n_out = 1'b0;
    assign o_fan_fault_n_oe = fault_oe_q;
    assign o_int_n = ~int_q;
endmodule
`default_nettype wire

// [testbench/ftm_props.sv]
`timescale 1ns/1ps
`default_nettype none
module ftm_props (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_s_axi_awvalid,
    input wire o_s_axi_awready,
    input wire i_s_axi_wvalid,
    input wire o_s_axi_wready,
    input wire o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire [1:0] o_s_axi_bresp,
    input wire i_s_axi_arvalid,
    input wire o_s_axi_arready,
    input wire [7:0] i_s_axi_araddr,
    input wire o_s_axi_rvalid,
    input wire i_s_axi_rready,
    input wire [31:0] o_s_axi_rdata,
    input wire o_fan_fault_n_out,
    input wire o_int_n
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence s_wr_taken;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    endsequence
    sequence s_rd_taken;
        i_s_axi_arvalid && o_s_axi_arready;
    endsequence
    AST_WR_BUSY: assert property (s_wr_taken |=> !o_s_axi_awready && !o_s_axi_wready)
        else $error("write channel ready while busy");
    AST_B_LATENCY: assert property (s_wr_taken |=> ##[0:1] o_s_axi_bvalid)
        else $error("write response late");
    AST_B_STANDS: assert property (o_s_axi_bvalid && !i_s_axi_bready
        |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response dropped");
    AST_R_LATENCY: assert property (s_rd_taken |=> o_s_axi_rvalid && !o_s_axi_arready)
        else $error("read data late");
    AST_R_STANDS: assert property (o_s_axi_rvalid && !i_s_axi_rready
        |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data dropped");
    AST_R_UPPER: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0)
        else $error("read upper bits set");
    AST_FAULT_OD: assert property (o_fan_fault_n_out == 1'b0)
        else $error("fault pin drives high");
    AST_INT_RELEASE: assert property (s_rd_taken ##0 i_s_axi_araddr == 8'h08
        |=> ##[0:2] o_int_n)
        else $error("interrupt kept after status read");
endmodule
bind ftm_top ftm_props u_ftm_props (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
    .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
    .o_s_axi_bresp(o_s_axi_bresp), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .i_s_axi_araddr(i_s_axi_araddr),
    .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
    .o_s_axi_rdata(o_s_axi_rdata), .o_fan_fault_n_out(o_fan_fault_n_out),
    .o_int_n(o_int_n));
`default_nettype wire

// [testbench/ftm_fan_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ftm_fan_model (
    input wire logic [31:0] i_period_cyc,
    input wire logic i_fault_oe,
    input wire logic i_fault_out,
    output logic o_tach,
    output wire logic o_fault_n
);
    // Open-drain line with board pull-up
    assign o_fault_n = i_fault_oe ? i_fault_out : 1'b1;
    // One tach rising edge per period; the extra ns keeps a zero period finite
    initial begin
        o_tach = 1'b1;
        // Let the bench set the period before the first delay is taken
        #1;
        forever begin
            #(50 * i_period_cyc + 1);
            o_tach = ~o_tach;
        end
    end
endmodule
`default_nettype wire

// [testbench/ftm_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ftm_map.vh"
module ftm_top_tb;
    localparam [7:0] PART = 8'h3C; // Arbitrary
    localparam [7:0] MAKER = 8'hC3; // Arbitrary
    localparam [3:0] REV = 4'h2; // Arbitrary
    localparam [1:0] OK = `FTM_RESP_OKAY;
    localparam [1:0] ER = `FTM_RESP_SLVERR;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, period;
    wire awready, wready, bvalid, arready, rvalid, tach, pwm, f_out, f_oe, int_n, flt_n;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer mismatches, tests_run;
    ftm_top #(.SPINUP_CYCLES(200), .PART_CODE(PART), .MAKER_CODE(MAKER), .REVISION(REV))
    u_ftm_top (.i_clock(clk), .i_rst_n(rst_n), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
        .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .i_s_axi_araddr(araddr),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .i_tach_sense_in(tach), .o_pwm_out(pwm),
        .o_fan_fault_n_out(f_out), .o_fan_fault_n_oe(f_oe), .o_int_n(int_n));
    ftm_fan_model u_ftm_fan_model (.i_period_cyc(period), .i_fault_oe(f_oe),
        .i_fault_out(f_out), .o_tach(tach), .o_fault_n(flt_n));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic results;
        if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bail;
        mismatches = mismatches + 1;
        results;
    endtask
    task automatic check(input [31:0] seen, input [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input [5:0] idx, input [7:0] d, input [1:0] er);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            {awvalid, wvalid, bready} <= 3'b110;
            awaddr <= {idx, 2'b00};
            wdata <= {24'h0, d};
            while (!(bvalid && bready)) begin
                @(posedge clk);
                n = n + 1;
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                if (bvalid) bready <= 1'b1;
                if (n > 50) bail;
            end
            check({30'h0, bresp}, {30'h0, er});
        end
    endtask
    task automatic rd(input [5:0] idx, output [31:0] d, output [1:0] r);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            {arvalid, rready} <= 2'b10;
            araddr <= {idx, 2'b00};
            while (!(rvalid && rready)) begin
                @(posedge clk);
                n = n + 1;
                if (arvalid && arready) arvalid <= 1'b0;
                if (rvalid) rready <= 1'b1;
                if (n > 50) bail;
            end
            d = rdata;
            r = rresp;
        end
    endtask
    task automatic chk(input [5:0] idx, input [7:0] ed, input [1:0] er);
        reg [31:0] d;
        reg [1:0] r;
        begin
            rd(idx, d, r);
            check(d, {24'h0, ed});
            check({30'h0, r}, {30'h0, er});
        end
    endtask
    task automatic settle(input v);
        integer n;
        reg bad;
        begin
            n = 0;
            bad = 1'b0;
            while (pwm !== v && n < 12000) begin
                @(posedge clk);
                n = n + 1;
            end
            repeat (700) begin
                @(posedge clk);
                if (pwm !== v) bad = 1'b1;
            end
            check({31'h0, bad}, 32'h0);
        end
    endtask
    task automatic t_regs;
        chk(`FTM_IDX_CFG1, `FTM_RST_CFG1, OK);
        chk(`FTM_IDX_CFG2, `FTM_RST_CFG2, OK);
        chk(`FTM_IDX_STS1, 8'h00, OK);
        chk(`FTM_IDX_STS2, 8'h00, OK);
        chk(`FTM_IDX_LIMIT, `FTM_RST_LIMIT, OK);
        chk(`FTM_IDX_PROF1, `FTM_RST_PROF1, OK);
        chk(`FTM_IDX_DRIVE, `FTM_RST_DRIVE, OK);
        chk(`FTM_IDX_FILT, `FTM_RST_FILT, OK);
        chk(`FTM_IDX_LAUTO, `FTM_RST_LAUTO, OK);
        chk(`FTM_IDX_RAUTO, `FTM_RST_RAUTO, OK);
        chk(`FTM_IDX_MAKER, MAKER, OK);
        wr(`FTM_IDX_PART, 8'h00, ER);
        chk(`FTM_IDX_PART, PART, OK);
        chk(`FTM_IDX_REV, {4'h0, REV}, OK);
        wr(`FTM_IDX_REV, 8'h80, OK);
        chk(`FTM_IDX_REV, {4'h8, REV}, OK);
        chk(6'h30, 8'h00, ER);
        wr(6'h30, 8'h12, ER);
        // Factory test place is left alone
    endtask
    task automatic t_invert;
        wr(`FTM_IDX_DRIVE, 8'h0F, OK);
        wr(`FTM_IDX_CFG1, 8'h91, OK);
        settle(1'b0);
        // Inversion set as for an n-channel drive
        wr(`FTM_IDX_CFG1, 8'h99, OK);
        settle(1'b1);
    endtask
    task automatic t_ranges;
        integer c, n, m, t;
        reg [31:0] d;
        reg [1:0] r;
        reg ok;
        begin
            period = 888;
            for (c = 0; c < 4; c = c + 1) begin
                wr(`FTM_IDX_PROF1, {c[1:0], 6'h1D}, OK);
                ok = 1'b0;
                n = 0;
                t = (`FTM_OSC_DIV << c) + 200;
                while (ok !== 1'b1 && n < 4000) begin
                    rd(`FTM_IDX_READ, d, r);
                    n = n + 1;
                    m = d[7:0] * (`FTM_OSC_DIV << c);
                    ok = (m + t >= 2 * period) && (m <= 2 * period + t);
                end
                check({31'h0, ok}, 32'h1);
            end
        end
    endtask
    task automatic t_fail;
        integer k, n;
        reg [31:0] d;
        reg [1:0] r;
        begin
            period = 900;
            wr(`FTM_IDX_DRIVE, 8'h00, OK);
            // Undivided tick so every reading of this fan is above zero
            wr(`FTM_IDX_PROF1, 8'h1D, OK);
            wr(`FTM_IDX_CFG1, 8'h9B, OK);
            wr(`FTM_IDX_LIMIT, 8'h00, OK);
            for (k = 1; k < 7; k = k + 1) begin
                n = 0;
                while (int_n !== 1'b0) begin
                    @(posedge clk);
                    n = n + 1;
                    if (n > 20000) bail;
                end
                repeat (3) @(posedge clk);
                check({31'h0, pwm}, 32'h1);
                check({31'h0, flt_n}, {31'h0, k < 5});
                rd(`FTM_IDX_STS1, d, r);
                check({31'h0, d[1]}, 32'h1);
                @(posedge clk);
                check({31'h0, int_n}, 32'h1);
                rd(`FTM_IDX_STS1, d, r);
                check({31'h0, d[1]}, 32'h0);
            end
            wr(`FTM_IDX_LIMIT, 8'hFF, OK);
            n = 0;
            while (flt_n !== 1'b1 && n < 30000) begin
                @(posedge clk);
                n = n + 1;
            end
            check({31'h0, flt_n}, 32'h1);
        end
    endtask
    initial begin
        mismatches = 0;
        tests_run = 0;
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata} = 48'h0;
        period = 1776;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_invert;
        t_ranges;
        t_fail;
        results;
    end
    initial begin
        repeat (95000) @(posedge clk);
        bail;
    end
endmodule
`default_nettype wire
